// ===== rtl/lgd_glass_ctrl.sv
// segment glass driver control, status and pin waveform logic
//
// Behaviour
// - enable bit high starts driver; it owns commons and segments per duty and mask.
// - enable low stops driver at once and frees all pins to port use.
// - low-power wave select applies from the next frame start.
// - frame flag set at frame start, same cycle display data latched.
// - interrupt needs flag, enable bit and cpu global enable.
// - flag clears when cpu vectors to the frame handler.
// - writing one to flag clears it; zero leaves it.
// - with low-power wave the flag sets every second frame.
// - blanking grounds all pins after current frame until cleared.
// - reserved bits of register a read zero, writes ignored.
// - clock select picks system clock or async clock input.
// - half bias bit picks 1/3 or 1/2 bias on non-static duty.
// - duty field selects static, 1/2, 1/3 or 1/4 duty.
// - commons unused by the duty stay port pins.
// - multiplexed duties use chosen bias; static uses static drive.
// - port mask code sets the number of driven segment pins.
// - small variant reserves top mask bit, reads zero.
// - blanking and wave select are copied at each frame start, data at each latching one.
// - low-power wave latches data only every second frame.
// - blanking leaves display memory untouched.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
module lgd_glass_ctrl #(
  parameter int unsigned SYS_TICK_DIV = lgd_pkg::SYS_TICK_DIV_DEF,
  parameter bit WIDE_VARIANT = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_lcd_clk,
  input wire logic vector_ack,
  input wire logic [4*lgd_pkg::NSEG-1:0] disp_data,
  output logic [2*lgd_pkg::NSEG-1:0] seg_level,
  output logic [lgd_pkg::NSEG-1:0] seg_drive_en,
  output logic [2*lgd_pkg::NCOM-1:0] com_level,
  output logic [lgd_pkg::NCOM-1:0] com_drive_en,
  output logic half_bias,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // functions

  // driven segment count for a port mask code
  function automatic logic [5:0] seg_count(input logic [3:0] m);
    logic [5:0] n;
    n = 6'd13;
    if (m < 4'h6) begin
      n = 6'd13 + {1'b0, m, 1'b0};
    end else if (m == 4'h6) begin
      n = 6'd24;
    end else if (m == 4'h7) begin
      n = 6'd25;
    end else if (m == 4'hf) begin
      n = 6'd40;
    end else begin
      n = 6'd27 + {1'b0, m - 4'h8, 1'b0};
    end
    return n;
  endfunction

  // common level: selected swings full, others sit at the bias level
  function automatic logic [1:0] com_lvl(input logic sel, input logic pol,
      input logic [1:0] duty, input logic hb);
    logic [1:0] v;
    v = pol ? lgd_pkg::LVL_GND : lgd_pkg::LVL_TOP;
    if (!sel) begin
      if (duty == lgd_pkg::DUTY_STATIC) begin
        v = pol ? lgd_pkg::LVL_GND : lgd_pkg::LVL_TOP;
      end else if (hb) begin
        v = lgd_pkg::LVL_MID;
      end else begin
        v = pol ? lgd_pkg::LVL_MID : lgd_pkg::LVL_LOW;
      end
    end
    return v;
  endfunction

  // segment level: on opposes the common, off stays near it
  function automatic logic [1:0] seg_lvl(input logic on, input logic pol,
      input logic [1:0] duty, input logic hb);
    logic [1:0] v;
    v = pol ? lgd_pkg::LVL_TOP : lgd_pkg::LVL_GND;
    if (!on) begin
      if (duty == lgd_pkg::DUTY_STATIC || hb) begin
        v = pol ? lgd_pkg::LVL_GND : lgd_pkg::LVL_TOP;
      end else begin
        v = pol ? lgd_pkg::LVL_LOW : lgd_pkg::LVL_MID;
      end
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers and apb decode

  logic en_r, lp_r, flag_r, ie_r, bl_r;
  logic cs_r, hb_r;
  logic [1:0] duty_r;
  logic [3:0] pm_r;
  logic pready_r, pslverr_r, irq_r, half_bias_r;
  logic [31:0] prdata_r;
  logic setup, access_wr, hit_a, hit_b, wr_a, wr_b;
  logic flag_set, flag_clr;

  assign setup = psel && !penable;
  assign access_wr = psel && penable && pready_r && pwrite;
  assign hit_a = (paddr == lgd_pkg::ADDR_A);
  assign hit_b = (paddr == lgd_pkg::ADDR_B);
  assign wr_a = access_wr && hit_a;
  assign wr_b = access_wr && hit_b;

  // zero-wait slave: ready in every access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !hit_a && !hit_b;
      prdata_r <= 32'h0000_0000;
      if (setup && !pwrite && hit_a) begin
        // reserved positions read zero
        prdata_r[lgd_pkg::A_EN] <= en_r;
        prdata_r[lgd_pkg::A_LP] <= lp_r;
        prdata_r[lgd_pkg::A_FLAG] <= flag_r;
        prdata_r[lgd_pkg::A_IE] <= ie_r;
        prdata_r[lgd_pkg::A_BL] <= bl_r;
      end else if (setup && !pwrite && hit_b) begin
        prdata_r[lgd_pkg::B_CS] <= cs_r;
        prdata_r[lgd_pkg::B_HB] <= hb_r;
        prdata_r[lgd_pkg::B_DUTY_HI:lgd_pkg::B_DUTY_LO] <= duty_r;
        prdata_r[lgd_pkg::B_PM_HI:lgd_pkg::B_PM_LO] <= pm_r;
      end
    end
  end

  // control register a, writable bits only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= lgd_pkg::A_RESET[lgd_pkg::A_EN];
      lp_r <= lgd_pkg::A_RESET[lgd_pkg::A_LP];
      ie_r <= lgd_pkg::A_RESET[lgd_pkg::A_IE];
      bl_r <= lgd_pkg::A_RESET[lgd_pkg::A_BL];
    end else if (wr_a) begin
      en_r <= pwdata[lgd_pkg::A_EN];
      lp_r <= pwdata[lgd_pkg::A_LP];
      ie_r <= pwdata[lgd_pkg::A_IE];
      bl_r <= pwdata[lgd_pkg::A_BL];
    end
  end

  // config register b
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_r <= lgd_pkg::B_RESET[lgd_pkg::B_CS];
      hb_r <= lgd_pkg::B_RESET[lgd_pkg::B_HB];
      duty_r <= lgd_pkg::B_RESET[lgd_pkg::B_DUTY_HI:lgd_pkg::B_DUTY_LO];
      pm_r <= lgd_pkg::B_RESET[lgd_pkg::B_PM_HI:lgd_pkg::B_PM_LO];
    end else if (wr_b) begin
      cs_r <= pwdata[lgd_pkg::B_CS];
      hb_r <= pwdata[lgd_pkg::B_HB];
      duty_r <= pwdata[lgd_pkg::B_DUTY_HI:lgd_pkg::B_DUTY_LO];
      pm_r[2:0] <= pwdata[2:0];
      pm_r[3] <= WIDE_VARIANT ? pwdata[3] : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // driver tick: system divider or synchronised async clock

  logic ck_s1_r, ck_s2_r, ck_s3_r;
  logic [15:0] div_r;
  logic sys_tick, async_tick, tick;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
    end else begin
      ck_s1_r <= ext_lcd_clk;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
    end
  end

  assign sys_tick = (div_r == 16'(SYS_TICK_DIV - 1));
  // async ticks land two to three pclk after the pin edge; the pin
  // must stay well below pclk/2 or edges are lost
  assign async_tick = ck_s2_r && !ck_s3_r;
  assign tick = cs_r ? async_tick : sys_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 16'h0000;
    end else if (sys_tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame sequencing and working copies

  logic running_r, pair_odd_r, fpol_r, lp_w_r, bl_w_r;
  logic [2:0] tcnt_r;
  logic [2:0] last_tick;
  logic frame_start, latch_now;
  logic [lgd_pkg::NCOM-1:0][lgd_pkg::NSEG-1:0] data_w_r;

  // a duty change mid frame can stretch that frame once: the tick
  // count runs on to its wrap before the shorter end value is met
  assign last_tick = (duty_r == lgd_pkg::DUTY_THIRD) ?
      lgd_pkg::LAST_TICK_THIRD : lgd_pkg::LAST_TICK_DEF;
  assign frame_start = en_r && tick && (!running_r || tcnt_r == last_tick);
  // low-power wave keeps data over a frame pair
  assign latch_now = !lp_r || !pair_odd_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_r <= 1'b0;
      tcnt_r <= 3'h0;
      pair_odd_r <= 1'b0;
      fpol_r <= 1'b0;
      lp_w_r <= 1'b0;
      bl_w_r <= 1'b0;
    end else if (!en_r) begin
      // stop at once, no frame boundary wait
      running_r <= 1'b0;
      tcnt_r <= 3'h0;
      pair_odd_r <= 1'b0;
      fpol_r <= 1'b0;
      bl_w_r <= 1'b0;
    end else if (frame_start) begin
      running_r <= 1'b1;
      tcnt_r <= 3'h0;
      pair_odd_r <= lp_r ? !pair_odd_r : 1'b0;
      fpol_r <= !fpol_r;
      lp_w_r <= lp_r;
      bl_w_r <= bl_r;
    end else if (tick) begin
      tcnt_r <= tcnt_r + 3'h1;
    end
  end

  // working copy only; memory stays as written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_w_r <= '0;
    end else if (frame_start && latch_now) begin
      data_w_r <= disp_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame flag and interrupt

  assign flag_set = frame_start && latch_now;
  // software clear and vector acknowledge share one path
  assign flag_clr = (wr_a && pwdata[lgd_pkg::A_FLAG]) || vector_ack;

  // a latching frame start in the clearing cycle keeps the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= lgd_pkg::A_RESET[lgd_pkg::A_FLAG];
    end else if (flag_set) begin
      flag_r <= 1'b1;
    end else if (flag_clr) begin
      flag_r <= 1'b0;
    end
  end

  // global interrupt gating lives in the cpu
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= flag_r && ie_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin waveforms

  logic [1:0] com_idx;
  logic half_bit, pol, mux_hb;
  logic [5:0] seg_n;

  always_comb begin
    com_idx = 2'h0;
    half_bit = tcnt_r[0];
    case (duty_r)
      lgd_pkg::DUTY_STATIC: begin
        com_idx = 2'h0;
        half_bit = tcnt_r[2];
      end
      lgd_pkg::DUTY_HALF: begin
        com_idx = {1'b0, tcnt_r[2]};
        half_bit = tcnt_r[1];
      end
      default: begin
        com_idx = tcnt_r[2:1];
        half_bit = tcnt_r[0];
      end
    endcase
  end

  // low-power wave flips polarity per frame, default per half slot
  assign pol = lp_w_r ? fpol_r : half_bit;
  // static duty ignores the bias bit
  assign mux_hb = hb_r && (duty_r != lgd_pkg::DUTY_STATIC);
  assign seg_n = seg_count(pm_r);

  // pins lag the frame state by one pclk so all of them move together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_level <= '0;
      seg_drive_en <= '0;
      com_level <= '0;
      com_drive_en <= '0;
      half_bias_r <= 1'b0;
    end else begin
      half_bias_r <= mux_hb;
      for (int s = 0; s < lgd_pkg::NSEG; s++) begin
        // masked pins stay with the port
        seg_drive_en[s] <= running_r && (6'(s) < seg_n);
        if (!running_r || bl_w_r) begin
          seg_level[2*s +: 2] <= lgd_pkg::LVL_GND;
        end else begin
          seg_level[2*s +: 2] <=
              seg_lvl(data_w_r[com_idx][s], pol, duty_r, mux_hb);
        end
      end
      for (int c = 0; c < lgd_pkg::NCOM; c++) begin
        // unused commons stay with the port
        com_drive_en[c] <= running_r && (2'(c) <= duty_r);
        if (!running_r || bl_w_r) begin
          com_level[2*c +: 2] <= lgd_pkg::LVL_GND;
        end else begin
          com_level[2*c +: 2] <=
              com_lvl(2'(c) == com_idx, pol, duty_r, mux_hb);
        end
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign half_bias = half_bias_r;

endmodule

// ===== rtl/lgd_pkg.sv
// constants for the segment glass driver control block
package lgd_pkg;
  // register indices; the byte address is four times the index
  localparam logic [9:0] IDX_A = 10'h0e4;
  localparam logic [9:0] IDX_B = 10'h0e5;
  localparam logic [11:0] ADDR_A = {IDX_A, 2'b00};
  localparam logic [11:0] ADDR_B = {IDX_B, 2'b00};

  // glass_ctrl_status_a fields
  localparam int A_EN = 7;
  localparam int A_LP = 6;
  localparam int A_FLAG = 4;
  localparam int A_IE = 3;
  localparam int A_BL = 0;
  localparam logic [7:0] A_RESET = 8'h00;

  // glass_ctrl_config_b fields
  localparam int B_CS = 7;
  localparam int B_HB = 6;
  localparam int B_DUTY_HI = 5;
  localparam int B_DUTY_LO = 4;
  localparam int B_PM_HI = 3;
  localparam int B_PM_LO = 0;
  localparam logic [7:0] B_RESET = 8'h00;

  // duty codes
  localparam logic [1:0] DUTY_STATIC = 2'h0;
  localparam logic [1:0] DUTY_HALF = 2'h1;
  localparam logic [1:0] DUTY_THIRD = 2'h2;
  localparam logic [1:0] DUTY_QUARTER = 2'h3;

  // ticks per frame: 8 for most duties, 6 for 1/3 duty
  localparam logic [2:0] LAST_TICK_DEF = 3'h7;
  localparam logic [2:0] LAST_TICK_THIRD = 3'h5;

  // pin level codes; MID is 2/3 at third bias, 1/2 at half bias
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_LOW = 2'h1;
  localparam logic [1:0] LVL_MID = 2'h2;
  localparam logic [1:0] LVL_TOP = 2'h3;

  localparam int NSEG = 40;
  localparam int NCOM = 4;
  localparam int SYS_TICK_DIV_DEF = 16;
endpackage

// ===== verif/lgd_glass_checker.sv
// concurrent checks on the glass driver control ports
`timescale 1ns/100ps
module lgd_glass_checker #(
  parameter int unsigned SYS_TICK_DIV = 16,
  parameter bit WIDE_VARIANT = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic vector_ack,
  input wire logic [79:0] seg_level,
  input wire logic [39:0] seg_drive_en,
  input wire logic [7:0] com_level,
  input wire logic [3:0] com_drive_en,
  input wire logic half_bias,
  input wire logic irq
);
  logic [7:0] b_r;
  logic [1:0] quiet_r;
  logic wr_a;
  logic wr_b;
  logic [39:0] smask;
  logic [3:0] cmask;
  int nseg;
  assign wr_a = psel && penable && pready && pwrite && paddr == lgd_pkg::ADDR_A;
  assign wr_b = psel && penable && pready && pwrite && paddr == lgd_pkg::ADDR_B;
  // shadow of config b; checks wait until outputs had time to follow it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) b_r <= lgd_pkg::B_RESET;
    else if (wr_b) b_r <= pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_r <= 2'h0;
    else if (wr_b) quiet_r <= 2'h0;
    else if (quiet_r != 2'h3) quiet_r <= quiet_r + 2'h1;
  end
  always_comb begin
    if (b_r[3:0] < 4'h6) nseg = 13 + 2 * int'(b_r[3:0]);
    else if (b_r[3:0] == 4'h6) nseg = 24;
    else if (b_r[3:0] == 4'h7) nseg = 25;
    else if (b_r[3:0] == 4'hf) nseg = 40;
    else nseg = 11 + 2 * int'(b_r[3:0]);
    smask = ~(40'hffffffffff << nseg);
    cmask = ~(4'hf << ({1'b0, b_r[5:4]} + 3'h1));
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_next: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not single access cycle");
  a_unmapped_err: assert property (pready && !pwrite &&
    paddr != lgd_pkg::ADDR_A && paddr != lgd_pkg::ADDR_B |->
    pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  a_reserved_zero: assert property (
    pready && !pwrite && paddr == lgd_pkg::ADDR_A |->
    prdata[31:8] == 24'h0 && !prdata[5] && prdata[2:1] == 2'h0)
    else $error("reserved bits not zero");
  a_disable_frees: assert property (
    wr_a && !pwdata[7] |-> ##3 seg_drive_en == 40'h0 &&
    com_drive_en == 4'h0 && seg_level == 80'h0 && com_level == 8'h0)
    else $error("pins held after disable");
  a_com_by_duty: assert property (
    quiet_r == 2'h3 && com_drive_en != 4'h0 |-> com_drive_en == cmask)
    else $error("commons differ from duty");
  a_seg_by_mask: assert property (
    quiet_r == 2'h3 && seg_drive_en != 40'h0 |-> seg_drive_en == smask)
    else $error("segments differ from mask");
  a_bias_follows: assert property (
    quiet_r == 2'h3 && com_drive_en != 4'h0 |->
    half_bias == (b_r[6] && b_r[5:4] != 2'h0))
    else $error("bias output wrong");
  a_ack_clears: assert property (vector_ack |-> ##2 !irq)
    else $error("irq kept after vector ack");
  a_irq_needs_ie: assert property (wr_a && !pwdata[3] |-> ##2 !irq)
    else $error("irq without enable");
endmodule
bind lgd_glass_ctrl lgd_glass_checker #(
  .SYS_TICK_DIV(SYS_TICK_DIV),
  .WIDE_VARIANT(WIDE_VARIANT)
) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .vector_ack, .seg_level, .seg_drive_en, .com_level,
  .com_drive_en, .half_bias, .irq
);

// ===== verif/lgd_panel_model.sv
// passive multiplexed glass panel seen from the driver pins
`timescale 1ns/100ps
module lgd_panel_model (
  input wire logic [79:0] seg_level,
  input wire logic [39:0] seg_drive_en,
  input wire logic [7:0] com_level,
  input wire logic [3:0] com_drive_en,
  output int n_seg,
  output int n_com,
  output logic all_gnd
);
  // glass only loads the pins: it knows which electrodes are driven
  assign n_seg = $countones(seg_drive_en);
  assign n_com = $countones(com_drive_en);
  // discharged only while still driven and every level is ground
  assign all_gnd = seg_level == 80'h0 && com_level == 8'h0 && |com_drive_en;
endmodule

// ===== verif/lgd_glass_ctrl_bench.sv
// self-checking bench for the glass driver control block
`timescale 1ns/100ps
module lgd_glass_ctrl_bench;
  localparam int DIV = 2;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, all_gnd;
  logic ext_lcd_clk, vector_ack, half_bias, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [159:0] disp_data;
  logic [79:0] seg_level;
  logic [39:0] seg_drive_en;
  logic [7:0] com_level, q, cfg;
  logic [3:0] com_drive_en;
  int n_seg, n_com, n_errors, cmp_count, t;
  lgd_glass_ctrl #(.SYS_TICK_DIV(DIV)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_lcd_clk, .vector_ack, .disp_data, .seg_level,
    .seg_drive_en, .com_level, .com_drive_en, .half_bias, .irq);
  lgd_panel_model u_panel (.seg_level, .seg_drive_en, .com_level,
    .com_drive_en, .n_seg, .n_com, .all_gnd);
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // slow clock not a multiple of pclk, so sync latency varies
  initial begin
    ext_lcd_clk = 1'b0;
    forever #20.3 ext_lcd_clk = ~ext_lcd_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [39:0] got, exp, input string nm);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // on segments swing opposite to the common selected right now
  task automatic chk_pins(input string nm);
    logic [39:0] on_seen, on_exp;
    int c;
    c = 0;
    on_seen = '0;
    on_exp = '0;
    for (int k = 0; k < 4; k++) begin
      if (com_drive_en[k] && (com_level[2*k +: 2] == 2'h0 ||
          com_level[2*k +: 2] == 2'h3)) begin
        c = k;
      end
    end
    for (int s = 0; s < 40; s++) begin
      if (seg_drive_en[s]) begin
        on_seen[s] = seg_level[2*s +: 2] == ~com_level[2*c +: 2];
        on_exp[s] = disp_data[40*c + s];
      end
    end
    chk(on_seen, on_exp, nm);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wflag;
    int n;
    n = 0;
    do begin
      apb(1'b0, lgd_pkg::ADDR_A, 8'h00);
      n++;
    end while (q[4] !== 1'b1 && n < 300);
    chk(q[4], 1'b1, "frame flag");
    repeat (2) @(posedge pclk);
  endtask
  // cycles between two irq rises; the first rise is acknowledged
  task automatic gap(output int n);
    do @(posedge pclk); while (irq !== 1'b1);
    vector_ack <= 1'b1;
    @(posedge pclk);
    vector_ack <= 1'b0;
    n = 1;
    do begin
      @(posedge pclk);
      n++;
    end while (irq !== 1'b1 || n < 5);
  endtask
  function automatic int seg_n(input logic [3:0] pm);
    if (pm < 4'h6) return 13 + 2 * pm;
    if (pm == 4'h6 || pm == 4'h7) return 18 + pm;
    if (pm == 4'hf) return 40;
    return 27 + 2 * (pm - 8);
  endfunction
  function automatic int flen(input logic [1:0] duty, input logic lp);
    return (duty == lgd_pkg::DUTY_THIRD ? 6 : 8) * DIV * (lp ? 2 : 1);
  endfunction
  task finish_test;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hbb5ce15f));
    {psel, penable, pwrite, vector_ack, presetn} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    disp_data = 160'h0;
    n_errors = 0;
    cmp_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, lgd_pkg::ADDR_A, 8'h00);
    chk(q, lgd_pkg::A_RESET, "reg a reset");
    apb(1'b0, lgd_pkg::ADDR_B, 8'h00);
    chk(q, lgd_pkg::B_RESET, "reg b reset");
    apb(1'b1, lgd_pkg::ADDR_B + 12'h4, 8'hff);
    chk(e, 1'b1, "unmapped error");
    apb(1'b0, lgd_pkg::ADDR_B + 12'h4, 8'h00);
    chk({e, q}, 9'h100, "unmapped read");
    cfg = 8'($urandom);
    apb(1'b1, lgd_pkg::ADDR_B, cfg);
    apb(1'b0, lgd_pkg::ADDR_B, 8'h00);
    chk(q, cfg, "reg b readback");
    for (int i = 0; i < 16; i++) begin
      cfg = {1'b0, 1'($urandom), i[1:0], i[3:0]};
      disp_data <= {$urandom, $urandom, $urandom, $urandom, $urandom};
      apb(1'b1, lgd_pkg::ADDR_B, cfg);
      apb(1'b1, lgd_pkg::ADDR_A, 8'h90);
      wflag;
      chk(n_seg, seg_n(i[3:0]), "driven segments");
      chk(n_com, i % 4 + 1, "driven commons");
      chk(half_bias, cfg[6] && i % 4 != 0, "half bias");
      chk_pins("segment data");
      apb(1'b1, lgd_pkg::ADDR_A, 8'h10);
      repeat (3) @(posedge pclk);
      chk(n_seg + n_com, 0, "pins freed");
    end
    apb(1'b1, lgd_pkg::ADDR_A, 8'hff);
    apb(1'b0, lgd_pkg::ADDR_A, 8'h00);
    chk(q & 8'hef, 8'hc9, "reg a readback");
    apb(1'b1, lgd_pkg::ADDR_A, 8'h10);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, lgd_pkg::ADDR_B, {2'h0, k[0] ? 2'h2 : 2'h3, 4'h7});
      apb(1'b1, lgd_pkg::ADDR_A, k[1] ? 8'hd8 : 8'h98);
      gap(t);
      chk(t, flen(k[0] ? 2'h2 : 2'h3, k[1]), "frame period");
      apb(1'b1, lgd_pkg::ADDR_A, 8'h10);
    end
    apb(1'b1, lgd_pkg::ADDR_A, 8'hc8);
    do @(posedge pclk); while (irq !== 1'b1);
    apb(1'b1, lgd_pkg::ADDR_A, 8'hc8);
    apb(1'b0, lgd_pkg::ADDR_A, 8'h00);
    chk(q[4], 1'b1, "flag kept");
    chk(irq, 1'b1, "irq raised");
    apb(1'b1, lgd_pkg::ADDR_A, 8'hd8);
    apb(1'b0, lgd_pkg::ADDR_A, 8'h00);
    chk(q[4], 1'b0, "flag cleared");
    apb(1'b1, lgd_pkg::ADDR_B, 8'h1f);
    apb(1'b1, lgd_pkg::ADDR_A, 8'h90);
    wflag;
    apb(1'b1, lgd_pkg::ADDR_A, 8'h91);
    wflag;
    chk(all_gnd, 1'b1, "blanked pins");
    apb(1'b1, lgd_pkg::ADDR_A, 8'h10);
    apb(1'b1, lgd_pkg::ADDR_B, 8'hbf);
    apb(1'b1, lgd_pkg::ADDR_A, 8'h88);
    gap(t);
    chk(t >= 60 && t <= 70, 1'b1, "async frame");
    chk_pins("data after blank");
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    finish_test;
  end
endmodule
